// ===== hdl/s2ar_top.sv
`timescale 1ns/1ps
module s2ar_top
    import s2ar_pkg::*;
#(
    parameter int N_ASYNC = N_ASYNC_DEF   // link ticks per window
)
(
    input  logic        hclk,
    input  logic        hresetn,
    input  logic        hsel,
    input  logic [31:0] haddr,
    input  logic [1:0]  htrans,
    input  logic        hwrite,
    input  logic [2:0]  hsize,
    input  logic [31:0] hwdata,
    input  logic        hready,
    output logic        hreadyout,
    output logic        hresp,
    output logic [31:0] hrdata,
    input  logic        sync_clock_mode,
    input  logic        pixel_tick,
    input  logic        link_tick,
    output logic [7:0]  misc_attr_b,
    output logic [23:0] m_to_stream,
    output logic [23:0] n_to_stream,
    output logic [6:0]  transfer_unit_size,
    output logic        pixels_one,
    output logic        pixels_two,
    output logic        pixels_four,
    output logic [31:0] words_per_lane_count
);
    localparam logic [23:0] N_ASYNC_V = 24'(N_ASYNC);

    typedef struct packed
    {
        s2ar_bus_st_t bus;      // idle or write data phase
        logic [11:0]  waddr;    // address of pending write
        logic [31:0]  rdata;    // read data for data phase
        logic [7:0]   misc;     // copy out to framing
        logic [23:0]  m_out;    // numerator to stream
        logic [23:0]  n_out;    // denominator to stream
        logic [6:0]   tu;       // size to framing
        logic [2:0]   pixw;     // width one-hot
        logic [31:0]  wpl;      // word count to framing
    } s2ar_top_st_t;
    s2ar_top_st_t st_q;
    s2ar_top_st_t st_d;

    // field values held in the register instances
    logic [7:0]  misc_q;
    logic [23:0] m_q;
    logic [6:0]  tu_q;
    logic [23:0] n_q;
    logic [2:0]  pixw_q;
    logic [31:0] wpl_q;

    // write strobes, one per register
    logic        we_misc;
    logic        we_m;
    logic        we_tu;
    logic        we_n;
    logic        we_pixw;
    logic        we_wpl;
    logic        wr_act;    // write data phase in progress
    logic        rd_take;   // read address phase accepted
    logic        wr_take;   // write address phase accepted
    logic [31:0] rd_mux;    // value for the addressed register

    s2ar_calc_if cif ();

    // ticks go straight to the ratio counter
    assign cif.pixel_tick = pixel_tick;
    assign cif.link_tick  = link_tick;

    // address phase decode
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_take = hsel && hready && htrans[1] && hwrite;
    assign wr_act  = (st_q.bus == S2AR_ST_WRITE);

    // strobes fire during the write data phase, hwdata is valid
    assign we_misc = wr_act && (st_q.waddr == OFF_MISC_B);
    assign we_m    = wr_act && (st_q.waddr == OFF_M);
    assign we_tu   = wr_act && (st_q.waddr == OFF_TU);
    assign we_n    = wr_act && (st_q.waddr == OFF_N);
    assign we_pixw = wr_act && (st_q.waddr == OFF_PIXW);
    assign we_wpl  = wr_act && (st_q.waddr == OFF_WPL);

    // reserved misc bits are masked off in the instance
    s2ar_field_reg #(.W(W_MISC), .RST(RST_MISC), .MASK(MASK_MISC))
        u_misc (.hclk(hclk), .hresetn(hresetn), .we(we_misc),
                .wdata(hwdata[7:0]), .q(misc_q));

    // numerator only ever holds what software wrote
    s2ar_field_reg #(.W(W_CR), .RST(RST_CR), .MASK(MASK_CR))
        u_m (.hclk(hclk), .hresetn(hresetn), .we(we_m),
             .wdata(hwdata[23:0]), .q(m_q));

    // bit zero is fixed so the size stays even
    s2ar_field_reg #(.W(W_TU), .RST(RST_TU), .MASK(MASK_TU))
        u_tu (.hclk(hclk), .hresetn(hresetn), .we(we_tu),
              .wdata(hwdata[6:0]), .q(tu_q));

    // denominator has no hardware write path at all
    s2ar_field_reg #(.W(W_CR), .RST(RST_CR), .MASK(MASK_CR))
        u_n (.hclk(hclk), .hresetn(hresetn), .we(we_n),
             .wdata(hwdata[23:0]), .q(n_q));

    // pixel port width code
    s2ar_field_reg #(.W(W_PIXW), .RST(RST_PIXW), .MASK(MASK_PIXW))
        u_pixw (.hclk(hclk), .hresetn(hresetn), .we(we_pixw),
                .wdata(hwdata[2:0]), .q(pixw_q));

    // per-lane word count, used as written
    s2ar_field_reg #(.W(W_WPL), .RST(RST_WPL), .MASK(MASK_WPL))
        u_wpl (.hclk(hclk), .hresetn(hresetn), .we(we_wpl),
               .wdata(hwdata), .q(wpl_q));

    // measured ratio for asynchronous clocking
    s2ar_mcalc #(.N_WIN(N_ASYNC))
        u_mcalc (.hclk(hclk), .hresetn(hresetn), .cif(cif));

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rd_mux = 32'h00000000;
        case (haddr[11:0])
            OFF_MISC_B: rd_mux = {24'h000000, misc_q};
            OFF_M:      rd_mux = {8'h00, m_q};
            OFF_TU:     rd_mux = {25'h0, tu_q};
            OFF_N:      rd_mux = {8'h00, n_q};
            OFF_PIXW:   rd_mux = {29'h0, pixw_q};
            OFF_WPL:    rd_mux = wpl_q;
            default:    rd_mux = 32'h00000000;
        endcase
    end

    // next state of bus slave and framing outputs
    always_comb
    begin
        st_d = st_q;
        // bus: a write owns one wait cycle so reads see new data
        case (st_q.bus)
            S2AR_ST_IDLE:
            begin
                if (wr_take)
                begin
                    st_d.bus   = S2AR_ST_WRITE;
                    st_d.waddr = haddr[11:0];
                end
                if (rd_take)
                    st_d.rdata = rd_mux;
            end
            S2AR_ST_WRITE:
            begin
                // hready is low here, no new address phase
                st_d.bus = S2AR_ST_IDLE;
            end
            default:
            begin
                st_d.bus = S2AR_ST_IDLE;
            end
        endcase
        // framing copies, one cycle behind the registers
        st_d.misc = misc_q;
        st_d.tu   = tu_q;
        st_d.wpl  = wpl_q;
        // async mode inserts the measured value instead
        if (sync_clock_mode)
        begin
            st_d.m_out = m_q;
            st_d.n_out = n_q;
        end
        else
        begin
            st_d.m_out = cif.m_calc;
            st_d.n_out = N_ASYNC_V;
        end
        // undefined width codes select no pixel lane
        case (pixw_q)
            PIXW_ONE:  st_d.pixw = 3'b001;
            PIXW_TWO:  st_d.pixw = 3'b010;
            PIXW_FOUR: st_d.pixw = 3'b100;
            default:   st_d.pixw = 3'b000;
        endcase
    end

    // one state register for the bus slave and framing copies
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q       <= '0;
            st_q.bus   <= S2AR_ST_IDLE;
            st_q.tu    <= RST_TU;
            st_q.misc  <= RST_MISC;
            st_q.m_out <= RST_CR;
            st_q.n_out <= RST_CR;
            st_q.pixw  <= 3'b100;
            st_q.wpl   <= RST_WPL;
        end
        else
            st_q <= st_d;
    end

    // outputs
    assign hreadyout            = !wr_act;
    assign hresp                = 1'b0;
    assign hrdata               = st_q.rdata;
    assign misc_attr_b          = st_q.misc;
    assign m_to_stream          = st_q.m_out;
    assign n_to_stream          = st_q.n_out;
    assign transfer_unit_size   = st_q.tu;
    assign pixels_one           = st_q.pixw[0];
    assign pixels_two           = st_q.pixw[1];
    assign pixels_four          = st_q.pixw[2];
    assign words_per_lane_count = st_q.wpl;

    // checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // helper: size not yet written since reset
    logic tu_fresh_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tu_fresh_q <= 1'b1;
        else if (we_tu)
            tu_fresh_q <= 1'b0;
    end

    // a write: address phase then its data phase
    sequence wr_to_seq(logic [11:0] off);
        wr_take && st_q.bus == S2AR_ST_IDLE && haddr[11:0] == off
        ##1 wr_act;
    endsequence

    // a read address phase of one register
    sequence rd_of_seq(logic [11:0] off);
        rd_take && st_q.bus == S2AR_ST_IDLE && haddr[11:0] == off;
    endsequence

    misc_fields_a: assert property (
        wr_to_seq(OFF_MISC_B) |=> ##1
            misc_attr_b[MISC_RSV_H:MISC_RSV_L] == 4'h0 &&
            misc_attr_b[MISC_STEREO_H:MISC_STEREO_L] ==
                $past(hwdata[MISC_STEREO_H:MISC_STEREO_L], 2) &&
            misc_attr_b[MISC_VT_EVEN] == $past(hwdata[MISC_VT_EVEN], 2))
        else $error("misc byte fields wrong after write");

    m_readback_a: assert property (
        rd_of_seq(OFF_M) |=> hrdata == {8'h00, $past(m_q)})
        else $error("numerator readback not the written value");

    m_insert_a: assert property (
        !sync_clock_mode |=> m_to_stream == $past(cif.m_calc))
        else $error("async numerator not inserted");

    n_hold_a: assert property (
        !we_n |=> $stable(n_q))
        else $error("denominator changed without a write");

    n_readback_a: assert property (
        rd_of_seq(OFF_N) |=> hrdata == {8'h00, $past(n_q)})
        else $error("denominator readback wrong");

    tu_reset_a: assert property (
        tu_fresh_q |-> tu_q == 7'h40 && transfer_unit_size == 7'h40)
        else $error("size not 64 before first write");

    tu_even_a: assert property (
        wr_to_seq(OFF_TU) |=> ##1
            transfer_unit_size == {$past(hwdata[6:1], 2), 1'b0})
        else $error("size write not masked to even");

    pix_decode_a: assert property (
        ##1 (pixels_four == ($past(pixw_q) == PIXW_FOUR)) &&
        (pixels_two == ($past(pixw_q) == PIXW_TWO)) &&
        (pixels_one == ($past(pixw_q) == PIXW_ONE)))
        else $error("pixel width decode wrong");

    pix_undef_a: assert property (
        $onehot0({pixels_one, pixels_two, pixels_four}))
        else $error("more than one pixel width selected");

    wpl_write_a: assert property (
        wr_to_seq(OFF_WPL) |=> ##1 words_per_lane_count ==
            $past(hwdata, 2))
        else $error("word count not passed to framing");

    wr_wait_a: assert property (
        wr_take && st_q.bus == S2AR_ST_IDLE |=> !hreadyout ##1 hreadyout)
        else $error("write wait state not exactly one cycle");

    // computed numerator never lands in the register
    m_sw_only_a: assert property (
        !we_m |=> $stable(m_q))
        else $error("numerator register changed without a write");

    // async denominator is the window length, register untouched
    n_insert_a: assert property (
        !sync_clock_mode && hresetn |=> n_to_stream == N_ASYNC_V)
        else $error("async denominator not inserted");

    // sync mode passes the software ratio one cycle later
    ratio_sync_a: assert property (
        sync_clock_mode && hresetn |=>
            m_to_stream == $past(m_q) && n_to_stream == $past(n_q))
        else $error("sync ratio not taken from registers");

    // reserved misc bits stay zero inside and at the framing side
    misc_rsv_a: assert property (
        misc_q[MISC_RSV_H:MISC_RSV_L] == 4'h0 &&
        misc_attr_b[MISC_RSV_H:MISC_RSV_L] == 4'h0)
        else $error("reserved misc bits set");

    // size is even in the register and at the framing side
    tu_bit0_a: assert property (
        !tu_q[0] && !transfer_unit_size[0])
        else $error("transfer unit size odd");

    // reads cost no wait state
    rd_no_wait_a: assert property (
        rd_take && st_q.bus == S2AR_ST_IDLE |=> hreadyout)
        else $error("read data phase not ready at once");

    // read data stands until the next accepted read
    rd_hold_a: assert property (
        !(rd_take && st_q.bus == S2AR_ST_IDLE) |=> $stable(hrdata))
        else $error("read data changed without a read");
endmodule

// ===== inc/s2ar_pkg.sv
package s2ar_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_MISC_B = 12'h528;
    localparam logic [11:0] OFF_M      = 12'h52c;
    localparam logic [11:0] OFF_TU     = 12'h530;
    localparam logic [11:0] OFF_N      = 12'h534;
    localparam logic [11:0] OFF_PIXW   = 12'h538;
    localparam logic [11:0] OFF_WPL    = 12'h53c;
    // field widths
    localparam int W_MISC = 8;
    localparam int W_CR   = 24;
    localparam int W_TU   = 7;
    localparam int W_PIXW = 3;
    localparam int W_WPL  = 32;
    // values after reset
    localparam logic [7:0]  RST_MISC = 8'h00;
    localparam logic [23:0] RST_CR   = 24'h000000;
    localparam logic [6:0]  RST_TU   = 7'h40;
    localparam logic [2:0]  RST_PIXW = 3'h4;
    localparam logic [31:0] RST_WPL  = 32'h00000000;
    // writable bits; reserved and fixed bits stay at reset value
    localparam logic [7:0]  MASK_MISC = 8'h87;
    localparam logic [23:0] MASK_CR   = 24'hffffff;
    localparam logic [6:0]  MASK_TU   = 7'h7e;
    localparam logic [2:0]  MASK_PIXW = 3'h7;
    localparam logic [31:0] MASK_WPL  = 32'hffffffff;
    // misc attribute field positions
    localparam int MISC_VT_EVEN  = 0;
    localparam int MISC_STEREO_L = 1;
    localparam int MISC_STEREO_H = 2;
    localparam int MISC_RSV_L    = 3;
    localparam int MISC_RSV_H    = 6;
    // pixel port width codes
    localparam logic [2:0] PIXW_ONE  = 3'h1;
    localparam logic [2:0] PIXW_TWO  = 3'h2;
    localparam logic [2:0] PIXW_FOUR = 3'h4;
    // clock and asynchronous ratio window (link ticks)
    localparam int CLK_PERIOD_NS = 50;
    localparam int N_ASYNC_DEF   = 32768;
    // bus slave states
    typedef enum logic [1:0] {
        S2AR_ST_IDLE  = 2'b01,
        S2AR_ST_WRITE = 2'b10
    } s2ar_bus_st_t;
endpackage

// ===== inc/s2ar_calc_if.sv
`timescale 1ns/1ps
interface s2ar_calc_if;
    logic        pixel_tick;   // one pixel clock event
    logic        link_tick;    // one link symbol event
    logic [23:0] m_calc;       // measured numerator
    logic        m_valid;      // at least one window done
    modport calc
    (
        input  pixel_tick,
        input  link_tick,
        output m_calc,
        output m_valid
    );
    modport top
    (
        output pixel_tick,
        output link_tick,
        input  m_calc,
        input  m_valid
    );
endinterface

// ===== hdl/s2ar_field_reg.sv
`timescale 1ns/1ps
module s2ar_field_reg
#(
    parameter int              W    = 8,
    parameter logic [W-1:0]    RST  = '0,
    parameter logic [W-1:0]    MASK = '1
)
(
    input  logic         hclk,
    input  logic         hresetn,
    input  logic         we,
    input  logic [W-1:0] wdata,
    output logic [W-1:0] q
);
    typedef struct packed
    {
        logic [W-1:0] val;   // stored field
    } s2ar_fr_st_t;
    s2ar_fr_st_t st_q;
    s2ar_fr_st_t st_d;

    // masked bits keep their reset value for good
    always_comb
    begin
        st_d = st_q;
        if (we)
        begin
            st_d.val = (wdata & MASK) | (RST & ~MASK);
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_q <= '{val: RST};
        else
            st_q <= st_d;
    end

    assign q = st_q.val;
endmodule

// ===== hdl/s2ar_mcalc.sv
`timescale 1ns/1ps
module s2ar_mcalc
#(
    parameter int N_WIN = 32768
)
(
    input  logic   hclk,
    input  logic   hresetn,
    s2ar_calc_if.calc cif
);
    localparam logic [23:0] WIN_LAST = 24'(N_WIN - 1);
    typedef struct packed
    {
        logic [23:0] pix_cnt;   // pixel events this window
        logic [23:0] win_cnt;   // link events this window
        logic [23:0] m;         // last finished measure
        logic        valid;     // a measure exists
    } s2ar_mc_st_t;
    s2ar_mc_st_t st_q;
    s2ar_mc_st_t st_d;

    // count pixel events across a window of link events
    always_comb
    begin
        st_d = st_q;
        if (cif.pixel_tick)
            st_d.pix_cnt = st_q.pix_cnt + 24'h000001;
        if (cif.link_tick)
        begin
            if (st_q.win_cnt == WIN_LAST)
            begin
                // this window's ratio becomes the numerator
                st_d.m = st_d.pix_cnt;
                st_d.valid = 1'b1;
                st_d.win_cnt = 24'h000000;
                st_d.pix_cnt = 24'h000000;
            end
            else
                st_d.win_cnt = st_q.win_cnt + 24'h000001;
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign cif.m_calc  = st_q.m;
    assign cif.m_valid = st_q.valid;
endmodule

// ===== testbench/test_mst_stream2_attribute_regs.sv
`timescale 1ns/1ps
module test_mst_stream2_attribute_regs;
    import s2ar_pkg::*;
    localparam int NW = 8;            // short ratio window keeps run brief
    logic        hclk = 1'b0;         // bus clock
    logic        hresetn;             // async reset, active low
    logic        hsel;                // slave select
    logic [31:0] haddr;               // byte address
    logic [1:0]  htrans;              // transfer type
    logic        hwrite;              // write flag
    logic [2:0]  hsize;               // always word
    logic [31:0] hwdata;              // write data
    logic        hready;              // bus ready, fed back
    logic        hreadyout;           // slave ready
    logic        hresp;               // response
    logic [31:0] hrdata;              // read data
    logic        sync_clock_mode;     // clocking mode select
    logic        pixel_tick;          // pixel event pulse
    logic        link_tick;           // link event pulse
    logic [7:0]  misc_attr_b;         // framing copies
    logic [23:0] m_to_stream;
    logic [23:0] n_to_stream;
    logic [6:0]  transfer_unit_size;
    logic        pixels_one;
    logic        pixels_two;
    logic        pixels_four;
    logic [31:0] words_per_lane_count;
    int          fails;               // mismatch count
    int          checked;             // comparison count
    logic [31:0] rd_v;                // last read data
    logic [11:0] offs [6];            // register table
    logic [31:0] rstv [6];
    logic [2:0]  codes [5];           // width codes, two undefined

    // one slave, so its ready is the bus ready
    assign hready = hreadyout;

    s2ar_top #(.N_ASYNC(NW)) s2ar_top_i
    (
        .hclk                 (hclk),
        .hresetn              (hresetn),
        .hsel                 (hsel),
        .haddr                (haddr),
        .htrans               (htrans),
        .hwrite               (hwrite),
        .hsize                (hsize),
        .hwdata               (hwdata),
        .hready               (hready),
        .hreadyout            (hreadyout),
        .hresp                (hresp),
        .hrdata               (hrdata),
        .sync_clock_mode      (sync_clock_mode),
        .pixel_tick           (pixel_tick),
        .link_tick            (link_tick),
        .misc_attr_b          (misc_attr_b),
        .m_to_stream          (m_to_stream),
        .n_to_stream          (n_to_stream),
        .transfer_unit_size   (transfer_unit_size),
        .pixels_one           (pixels_one),
        .pixels_two           (pixels_two),
        .pixels_four          (pixels_four),
        .words_per_lane_count (words_per_lane_count)
    );

    // 50 ns period
    always #(CLK_PERIOD_NS / 2) hclk = ~hclk;

    // verdict and end of run
    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // single compare for every kind of value
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ready and read data are taken at the edge that samples them
    task automatic wait_rdy();
        for (int n = 0; n < 20; n++)
        begin
            @(posedge hclk);
            if (hready === 1'b1)
            begin
                rd_v = hrdata;
                return;
            end
        end
        fails++;
        print_verdict();
    endtask

    // write: address phase, then data phase held until ready
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b1;
        haddr  <= {20'h00000, a};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask

    // read: data taken at the edge that sees ready in the data phase
    task automatic bus_rd(input logic [11:0] a);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b0;
        haddr  <= {20'h00000, a};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        wait_rdy();
    endtask

    // ratio ticks: three pixel events between link events
    task automatic run_ticks();
        for (int i = 0; i < 160; i++)
        begin
            link_tick  <= (i % 4 == 0);
            pixel_tick <= (i % 4 != 0);
            @(posedge hclk);
        end
        link_tick  <= 1'b0;
        pixel_tick <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask

    // main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        sync_clock_mode = 1'b1;
        pixel_tick = 1'b0;
        link_tick = 1'b0;
        fails = 0;
        checked = 0;
        rd_v = '0;
        offs = '{OFF_MISC_B, OFF_M, OFF_TU, OFF_N, OFF_PIXW, OFF_WPL};
        rstv = '{32'h0, 32'h0, 32'h40, 32'h0, 32'h4, 32'h0};
        codes = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h7};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values of the whole table
        for (int i = 0; i < 6; i++)
        begin
            bus_rd(offs[i]);
            chk("reset value", rstv[i], rd_v);
        end
        // reserved misc bits hold zero
        bus_wr(OFF_MISC_B, 32'hffffffff);
        bus_rd(OFF_MISC_B);
        chk("misc", 32'h87, rd_v);
        chk("misc out", 32'h87, {24'h0, misc_attr_b});
        bus_wr(OFF_MISC_B, 32'h78);
        bus_rd(OFF_MISC_B);
        chk("misc", 32'h00, rd_v);
        // size bit zero never stored
        bus_wr(OFF_TU, 32'h3f);
        bus_rd(OFF_TU);
        chk("tu size", 32'h3e, rd_v);
        bus_wr(OFF_TU, 32'h21);
        bus_rd(OFF_TU);
        chk("tu size", 32'h20, rd_v);
        @(negedge hclk);
        chk("tu out", 32'h20, {25'h0, transfer_unit_size});
        @(posedge hclk);
        // three defined and two undefined width codes, decode is the code itself or nothing
        for (int i = 0; i < 5; i++)
        begin
            bus_wr(OFF_PIXW, {29'h0, codes[i]});
            bus_rd(OFF_PIXW);
            chk("width code", {29'h0, codes[i]}, rd_v);
            @(negedge hclk);
            chk("width out", (i < 3) ? {29'h0, codes[i]} : 32'h0,
                {29'h0, pixels_four, pixels_two, pixels_one});
            @(posedge hclk);
        end
        // multi-stream use leaves the four-pixel port selected
        bus_wr(OFF_PIXW, {29'h0, PIXW_FOUR});
        bus_rd(OFF_PIXW);
        chk("width mst", 32'h4, rd_v);
        chk("four out", 32'h4,
            {29'h0, pixels_four, pixels_two, pixels_one});
        // 1920 pixels at 24 bits over four lanes
        bus_wr(OFF_WPL, (1920 * 24 + 15) / 16 - 4);
        bus_rd(OFF_WPL);
        chk("word count", 32'd2876, rd_v);
        // unmapped place: write lost, reads zero
        bus_wr(12'h600, 32'hffffffff);
        bus_rd(12'h600);
        chk("unmapped", 32'h0, rd_v);
        chk("hresp", 32'h0, {31'h0, hresp});
        // synchronous mode uses the software ratio
        bus_wr(OFF_M, 32'h00123456);
        bus_wr(OFF_N, 32'h0000abcd);
        @(negedge hclk);
        chk("m out sync", 32'h123456, {8'h0, m_to_stream});
        chk("n out sync", 32'h00abcd, {8'h0, n_to_stream});
        chk("word out", 32'd2876, words_per_lane_count);
        @(posedge hclk);
        // asynchronous mode measures, readback untouched
        sync_clock_mode <= 1'b0;
        run_ticks();
        @(negedge hclk);
        chk("m out async", 32'd24, {8'h0, m_to_stream});
        chk("n out async", NW, {8'h0, n_to_stream});
        @(posedge hclk);
        bus_rd(OFF_M);
        chk("m readback", 32'h00123456, rd_v);
        bus_rd(OFF_N);
        chk("n readback", 32'h0000abcd, rd_v);
        // second reset in mid-run
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus_rd(OFF_TU);
        chk("tu after reset", 32'h40, rd_v);
        print_verdict();
    end
endmodule
